/* common/esid_defines.svh */
// constants for the external switch input decoder
// Operation
// - sixteen on/off switch inputs are sampled
// - inputs 1-4 issue run/hold/reset/advance on rise
// - inputs 5-8 take selectable functions
// - soak OR: switch on or in band
// - soak AND: switch on and in band
// - inputs 9-14 select program, BCD or binary
// - BCD: units 1,2,4,8; tens 10,20
// - binary: six bits, weights 1 to 32
// - BCD range limited to 1-39
// - number zero leaves keys and link selecting
// - switch selection only in READY program mode
// - inputs 15/16 cancel channel one/two
// - autoload and sensor check never cancelled
// - dual channel sync ignored for switches
// - run refused if enabled channel lacks program
// - act on changes within 0.2 seconds
// - numbers above 49 are invalid
`ifndef ESID_DEFINES_SVH
`define ESID_DEFINES_SVH
`define ESID_NUM_SW        16
`define ESID_PROG_MAX_BIN  6'h31
`define ESID_PROG_MAX_BCD  6'h27
`define ESID_CLK_HZ        50000000
`define ESID_REACT_MS      200
`define ESID_REACT_CYC     ((`ESID_CLK_HZ / 1000) * `ESID_REACT_MS)
`define ESID_HOLD_MS       400
`endif

/* common/esid_pkg.sv */
// types for the external switch input decoder
package esid_pkg;
   typedef enum logic [2:0] {
      ESID_FN_RAMP_END,
      ESID_FN_FAST,
      ESID_FN_SOAK_OR,
      ESID_FN_SOAK_AND,
      ESID_FN_MANUAL_AUTO,
      ESID_FN_AUTO_TUNING,
      ESID_FN_AUTOLOAD,
      ESID_FN_SENSOR_CHECK
   } esid_fn_type;

   typedef struct packed {
      logic run;
      logic hold;
      logic reset;
      logic segment_advance;
      logic ramp_end;
      logic fast;
      logic manual_auto;
      logic auto_tuning;
   } esid_cmd_type;

   typedef struct packed {
      logic       valid;
      logic [5:0] number;
   } esid_prog_type;
endpackage

/* core/esid_decoder.sv */
// external switch decoder for a two-channel program controller
`timescale 1ns/100ps
`include "esid_defines.svh"
module esid_decoder
   import esid_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic [15:0]   ext_switch_input,
   input  esid_fn_type        selectable_function_setting [4],
   input  wire logic          program_code_select,
   input  wire logic          dual_channel_sync,
   input  wire logic          ch1_ready,
   input  wire logic          ch2_ready,
   input  wire logic          ch1_has_program,
   input  wire logic          ch2_has_program,
   input  wire logic          ch1_soak_wait,
   input  wire logic          ch2_soak_wait,
   input  wire logic          ch1_pv_in_band,
   input  wire logic          ch2_pv_in_band,
   output esid_cmd_type       ch1_cmd,
   output esid_cmd_type       ch2_cmd,
   output logic [1:0]         soak_release,
   output logic               autoload_pulse,
   output logic               sensor_check_pulse,
   output esid_prog_type      ch1_prog,
   output esid_prog_type      ch2_prog,
   output logic [1:0]         key_select_allowed,
   output logic               run_refused
);
   ////////////////////////////////////////////////////////////////////
   logic [15:0] lvl;
   logic [15:0] rse;
   logic [15:0] fll;

   genvar g;
   generate
      for (g = 0; g < `ESID_NUM_SW; g++) begin : g_sync
         esid_sync u_sync (
            .clk    (clk),
            .arst_n (arst_n),
            .din    (ext_switch_input[g]),
            .level  (lvl[g]),
            .rise   (rse[g]),
            .fall   (fll[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // channel enables; dual_channel_sync deliberately not read
   logic en1;
   logic en2;
   assign en1 = ~lvl[14];
   assign en2 = ~lvl[15];

   // run refused if an enabled channel has no program
   logic run_ok;
   assign run_ok = (ch1_has_program | ~en1) & (ch2_has_program | ~en2);

   function automatic logic fn_pulse(input esid_fn_type sel [4], input esid_fn_type f,
                                     input logic [3:0] r, input logic [3:0] fl,
                                     input logic both);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (sel[i] == f) begin
            p = p | r[i] | (both & fl[i]);
         end
      end
      return p;
   endfunction

   function automatic logic fn_level(input esid_fn_type sel [4], input esid_fn_type f,
                                     input logic [3:0] l);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (sel[i] == f) begin
            p = p | l[i];
         end
      end
      return p;
   endfunction

   esid_cmd_type raw_d;
   always_comb begin
      raw_d                 = '0;
      raw_d.run             = rse[0] & run_ok;
      raw_d.hold            = rse[1];
      raw_d.reset           = rse[2];
      raw_d.segment_advance = rse[3];
      raw_d.ramp_end    = fn_pulse(selectable_function_setting, ESID_FN_RAMP_END,
                                   rse[7:4], fll[7:4], 1'b0);
      raw_d.fast        = fn_pulse(selectable_function_setting, ESID_FN_FAST,
                                   rse[7:4], fll[7:4], 1'b0);
      raw_d.manual_auto = fn_pulse(selectable_function_setting, ESID_FN_MANUAL_AUTO,
                                   rse[7:4], fll[7:4], 1'b1);
      raw_d.auto_tuning = fn_pulse(selectable_function_setting, ESID_FN_AUTO_TUNING,
                                   rse[7:4], fll[7:4], 1'b1);
   end

   // command pulses, registered: about 3 cycles after a pin change, far inside 0.2 s
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ch1_cmd <= '0;
         ch2_cmd <= '0;
      end else begin
         ch1_cmd <= en1 ? raw_d : '0;
         ch2_cmd <= en2 ? raw_d : '0;
      end
   end

   // not gated by cancel inputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         autoload_pulse     <= 1'b0;
         sensor_check_pulse <= 1'b0;
      end else begin
         autoload_pulse     <= fn_pulse(selectable_function_setting, ESID_FN_AUTOLOAD,
                                        rse[7:4], fll[7:4], 1'b0);
         sensor_check_pulse <= fn_pulse(selectable_function_setting, ESID_FN_SENSOR_CHECK,
                                        rse[7:4], fll[7:4], 1'b0);
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic soak_or_sw;
   logic soak_and_sw;
   logic soak_or_used;
   logic soak_and_used;
   always_comb begin
      soak_or_sw    = fn_level(selectable_function_setting, ESID_FN_SOAK_OR, lvl[7:4]);
      soak_and_sw   = fn_level(selectable_function_setting, ESID_FN_SOAK_AND, lvl[7:4]);
      soak_or_used  = fn_level(selectable_function_setting, ESID_FN_SOAK_OR, 4'hF);
      soak_and_used = fn_level(selectable_function_setting, ESID_FN_SOAK_AND, 4'hF);
   end

   // with neither form assigned, the band alone releases the wait
   function automatic logic soak_rel(input logic en, input logic band);
      logic r;
      r = band;
      if (en && soak_and_used) begin
         r = soak_and_sw & band;
      end else if (en && soak_or_used) begin
         r = soak_or_sw | band;
      end
      return r;
   endfunction

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         soak_release <= 2'h0;
      end else begin
         soak_release[0] <= ch1_soak_wait & soak_rel(en1, ch1_pv_in_band);
         soak_release[1] <= ch2_soak_wait & soak_rel(en2, ch2_pv_in_band);
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [5:0] prog_num;
   logic       prog_ok;
   always_comb begin
      if (program_code_select) begin
         prog_num = lvl[13:8];
         prog_ok  = prog_num <= `ESID_PROG_MAX_BIN;
      end else begin
         prog_num = 6'({2'h0, lvl[11:8]} + 6'(lvl[12]) * 6'h0A
                       + 6'(lvl[13]) * 6'h14);
         prog_ok  = (lvl[11:8] <= 4'h9) && (prog_num <= `ESID_PROG_MAX_BCD);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ch1_prog <= '0;
         ch2_prog <= '0;
      end else begin
         ch1_prog.number <= prog_num;
         ch2_prog.number <= prog_num;
         ch1_prog.valid  <= en1 & ch1_ready & prog_ok & (prog_num != 6'h00);
         ch2_prog.valid  <= en2 & ch2_ready & prog_ok & (prog_num != 6'h00);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         key_select_allowed <= 2'h3;
         run_refused        <= 1'b0;
      end else begin
         key_select_allowed[0] <= ~en1 | (prog_num == 6'h00);
         key_select_allowed[1] <= ~en2 | (prog_num == 6'h00);
         run_refused           <= rse[0] & (en1 | en2) & ~run_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_cancel1;
      @(posedge clk) disable iff (!arst_n) $past(lvl[14]) |-> ch1_cmd == '0;
   endproperty
   a_cancel1: assert property (p_cancel1) else $error("cancelled ch1 got command");

   property p_run_refuse;
      @(posedge clk) disable iff (!arst_n)
         (rse[0] && en1 && !ch1_has_program) |=> !ch1_cmd.run && !ch2_cmd.run;
   endproperty
   a_run_refuse: assert property (p_run_refuse) else $error("run not refused");

   property p_prog_range;
      @(posedge clk) disable iff (!arst_n)
         ch1_prog.valid |-> ch1_prog.number >= 6'h01 && ch1_prog.number <= `ESID_PROG_MAX_BIN;
   endproperty
   a_prog_range: assert property (p_prog_range) else $error("bad program number");

   property p_bcd_limit;
      @(posedge clk) disable iff (!arst_n)
         (!$past(program_code_select) && ch2_prog.valid) |-> ch2_prog.number <= `ESID_PROG_MAX_BCD;
   endproperty
   a_bcd_limit: assert property (p_bcd_limit) else $error("bcd beyond 39");

   property p_ready_only;
      @(posedge clk) disable iff (!arst_n) !$past(ch1_ready) |-> !ch1_prog.valid;
   endproperty
   a_ready_only: assert property (p_ready_only) else $error("selection outside ready");

   property p_hold_edge;
      @(posedge clk) disable iff (!arst_n) (rse[1] && en2) |=> ch2_cmd.hold;
   endproperty
   a_hold_edge: assert property (p_hold_edge) else $error("hold edge lost");

   property p_soak_and;
      @(posedge clk) disable iff (!arst_n)
         (en1 && soak_and_used && !ch1_pv_in_band) |=> !soak_release[0];
   endproperty
   a_soak_and: assert property (p_soak_and) else $error("and release without band");

   property p_autoload;
      @(posedge clk) disable iff (!arst_n)
         (rse[4] && selectable_function_setting[0] == ESID_FN_AUTOLOAD) |=> autoload_pulse;
   endproperty
   a_autoload: assert property (p_autoload) else $error("autoload lost");
endmodule

/* core/esid_sync.sv */
// two-flop synchroniser with edge pulses for one input
`timescale 1ns/100ps
module esid_sync (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;

   property p_rise_once;
      @(posedge clk) disable iff (!arst_n) rise |=> !rise;
   endproperty
   a_rise_once: assert property (p_rise_once) else $error("rise pulse too long");
endmodule

/* test/esid_switch_model.sv */
// contact bank model standing in front of the switch decoder
`timescale 1ns/100ps
module esid_switch_model #(
   parameter int HOLD_CYC = 8
) (
   input  wire logic clk,
   output logic [15:0] ext_switch_input
);
   initial ext_switch_input = 16'h0000;
   ////////////////////////////////////////
   // contacts only move just after a falling edge
   task automatic put(input logic [15:0] v);
      @(negedge clk);
      ext_switch_input = v;
   endtask
   // number settles before run rises; hold scaled down from 0.4 s
   task automatic start_run(input logic [5:0] num);
      put({ext_switch_input[15:14], num, ext_switch_input[7:1], 1'b0});
      repeat (HOLD_CYC) @(negedge clk);
      ext_switch_input[0] = 1'b1;
      repeat (HOLD_CYC) @(negedge clk);
      ext_switch_input[0] = 1'b0;
   endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the switch decoder
`timescale 1ns/100ps
module tb_top
   import esid_pkg::*;
;
   logic          clk = 1'b0;
   logic          arst_n = 1'b0;
   logic [15:0]   sw;
   esid_fn_type   sel [4];
   logic          pcs = 1'b0, dcs = 1'b0, c1, c2, rf;
   logic [1:0]    rdy = 2'b11, hp = 2'b11, sk = 2'b00, bnd = 2'b00;
   esid_cmd_type  ch1_cmd, ch2_cmd;
   esid_prog_type ch1_prog, ch2_prog;
   logic [1:0]    soak_release, key_select_allowed;
   logic          autoload_pulse, sensor_check_pulse, run_refused;
   int            err_count = 0, total_checks = 0, k;
   int            cnt1 [8], cnt2 [8], cnt_al, cnt_sc, cnt_rf;
   logic [6:0]    ep;
   logic [5:0]    v;
   logic [5:0]    corner [5] = '{6'h00, 6'h39, 6'h0A, 6'h31, 6'h32};
   always #10 clk = ~clk;
   esid_switch_model #(.HOLD_CYC(8)) i_esid_switch_model (.clk(clk), .ext_switch_input(sw));
   esid_decoder i_esid_decoder (.clk(clk), .arst_n(arst_n), .ext_switch_input(sw),
      .selectable_function_setting(sel), .program_code_select(pcs),
      .dual_channel_sync(dcs), .ch1_ready(rdy[0]), .ch2_ready(rdy[1]),
      .ch1_has_program(hp[0]), .ch2_has_program(hp[1]), .ch1_soak_wait(sk[0]),
      .ch2_soak_wait(sk[1]), .ch1_pv_in_band(bnd[0]), .ch2_pv_in_band(bnd[1]),
      .ch1_cmd(ch1_cmd), .ch2_cmd(ch2_cmd), .soak_release(soak_release),
      .autoload_pulse(autoload_pulse), .sensor_check_pulse(sensor_check_pulse),
      .ch1_prog(ch1_prog), .ch2_prog(ch2_prog), .key_select_allowed(key_select_allowed),
      .run_refused(run_refused));
   ////////////////////////////////////////
   always @(posedge clk) begin
      for (int j = 0; j < 8; j++) begin
         cnt1[j] += int'(ch1_cmd[j] === 1'b1);
         cnt2[j] += int'(ch2_cmd[j] === 1'b1);
      end
      cnt_al += int'(autoload_pulse === 1'b1);
      cnt_sc += int'(sensor_check_pulse === 1'b1);
      cnt_rf += int'(run_refused === 1'b1);
   end
   task automatic clr();
      foreach (cnt1[j]) begin
         cnt1[j] = 0;
         cnt2[j] = 0;
      end
      cnt_al = 0;
      cnt_sc = 0;
      cnt_rf = 0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_lvl(input logic [6:0] g, input logic [6:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t level got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_cnt(input int g, input int e);
      total_checks++;
      if (g != e) begin
         err_count++;
         $display("[FAIL] %0t pulses got %0d exp %0d", $time, g, e);
      end
   endtask
   // number bits are meaningless once valid is low
   function automatic logic [6:0] msk(input logic [6:0] p);
      return p[6] ? p : 7'h00;
   endfunction
   function automatic logic [6:0] exp_prog(input logic [5:0] v, input logic bin);
      logic [5:0] n;
      n = bin ? v : 6'(v[3:0]) + 6'h0A * 6'(v[5:4]);
      return {(n != 6'h00) && (n <= (bin ? 6'h31 : 6'h27)) && (bin || v[3:0] <= 4'h9), n};
   endfunction
   task automatic close_out();
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      cyc(20000);
      err_count++;
      close_out();
   end
   initial begin
      foreach (sel[j]) sel[j] = ESID_FN_RAMP_END;
      void'($urandom(62386));
      cyc(16);
      arst_n = 1'b1;
      cyc(6);
      chk_lvl(7'(key_select_allowed), 7'h03);
      for (k = 0; k < 16; k++) begin
         {c2, c1, hp} = 4'(k);
         dcs = 1'($urandom);
         i_esid_switch_model.put({c2, c1, 14'h0000});
         cyc(6);
         clr();
         i_esid_switch_model.start_run(6'h00);
         cyc(6);
         rf = (!hp[0] && !c1) || (!hp[1] && !c2);
         chk_cnt(cnt_rf, int'(rf));
         chk_cnt(cnt1[7], int'(!rf && !c1));
         chk_cnt(cnt2[7], int'(!rf && !c2));
      end
      hp = 2'b11;
      for (k = 1; k < 4; k++) begin
         c1 = 1'($urandom);
         i_esid_switch_model.put({1'b0, c1, 14'h0000});
         cyc(6);
         clr();
         i_esid_switch_model.put({1'b0, c1, 14'h0000} | (16'h0001 << k));
         cyc(6);
         i_esid_switch_model.put({1'b0, c1, 14'h0000});
         cyc(6);
         chk_cnt(cnt1[7 - k], int'(!c1));
         chk_cnt(cnt2[7 - k], 1);
      end
      for (k = 0; k < 8; k++) begin
         if (k == 2 || k == 3) continue;
         foreach (sel[j]) sel[j] = esid_fn_type'(k);
         c1 = (k > 5);
         i_esid_switch_model.put({c1, c1, 14'h0000});
         cyc(6);
         clr();
         i_esid_switch_model.put({c1, c1, 14'h0010});
         cyc(6);
         i_esid_switch_model.put({c1, c1, 14'h0000});
         cyc(6);
         if (k > 5) chk_cnt((k == 6) ? cnt_al : cnt_sc, 1);
         else chk_cnt(cnt1[(k < 2) ? 3 - k : 5 - k] + cnt2[(k < 2) ? 3 - k : 5 - k],
                      (k > 3) ? 4 : 2);
      end
      sk = 2'b11;
      for (k = 0; k < 8; k++) begin
         foreach (sel[j]) sel[j] = k[2] ? ESID_FN_SOAK_AND : ESID_FN_SOAK_OR;
         bnd = {k[0], k[0]};
         i_esid_switch_model.put({11'h000, k[1], 4'h0});
         cyc(6);
         rf = k[2] ? k[1] & k[0] : k[1] | k[0];
         chk_lvl(7'(soak_release), {5'h00, rf, rf});
      end
      for (k = 0; k < 45; k++) begin
         v = (k < 5) ? corner[k] : 6'($urandom);
         pcs = (k < 5) ? (k > 2) : 1'($urandom);
         rdy = 2'($urandom) | ((k < 5) ? 2'b11 : 2'b00);
         c2 = 1'($urandom);
         i_esid_switch_model.put({c2, 1'b0, v, 8'h00});
         cyc(6);
         ep = exp_prog(v, pcs);
         chk_lvl(msk(ch1_prog), msk({ep[6] & rdy[0], ep[5:0]}));
         chk_lvl(msk(ch2_prog), msk({ep[6] & rdy[1] & !c2, ep[5:0]}));
         chk_lvl(7'(key_select_allowed), {5'h00, c2 | (v == 6'h00), v == 6'h00});
      end
      close_out();
   end
endmodule
